// file: common/pco_pkg.sv
package pco_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] PCO_OFF_CTRL = 4'h0;  // Control fields
  localparam logic [3:0] PCO_OFF_FLAG = 4'h4;  // Interrupt output flag
  localparam logic [3:0] PCO_OFF_TRIM = 4'h8;  // Oscillator trim
  localparam logic [3:0] PCO_OFF_STAT = 4'hC;  // Status, read only
  // ==========================================================
  // Control field positions
  localparam int PCO_B_SEL_LO = 0;  // Select field low bit
  localparam int PCO_B_SEL_HI = 2;  // Select field high bit
  localparam int PCO_B_OE = 3;      // Output enable bit
  localparam int PCO_B_SY = 4;      // Synchronised switching
  localparam int PCO_B_IE = 5;      // Interrupt output enable
  localparam int PCO_B_RST = 6;     // Prescaler reset, write only
  localparam int PCO_B_FLAG = 0;    // Flag bit in flag register
  // ==========================================================
  // Select codes
  localparam logic [2:0] PCO_SEL_OSC = 3'h0;   // Raw oscillator
  localparam logic [2:0] PCO_SEL_8K = 3'h1;    // 8192 Hz
  localparam logic [2:0] PCO_SEL_1K = 3'h2;    // 1024 Hz
  localparam logic [2:0] PCO_SEL_64 = 3'h3;    // 64 Hz
  localparam logic [2:0] PCO_SEL_32 = 3'h4;    // 32 Hz
  localparam logic [2:0] PCO_SEL_1HZ = 3'h5;   // 1 Hz
  localparam logic [2:0] PCO_SEL_TMR = 3'h6;   // Timer interrupt
  localparam logic [2:0] PCO_SEL_LOW = 3'h7;   // Constant low
  // ==========================================================
  // Divider taps on the oscillator falling-edge counter
  localparam int PCO_DIV_W = 15;     // Counter width, 1 Hz at top
  localparam int PCO_TAP_8K = 1;     // 8192 Hz bit
  localparam int PCO_TAP_1K = 4;     // 1024 Hz bit
  localparam int PCO_TAP_64 = 8;     // 64 Hz bit
  localparam int PCO_TAP_32 = 9;     // 32 Hz bit
  localparam int PCO_TAP_1HZ = 14;   // 1 Hz bit
  // ==========================================================
  // Reset values and bus answers
  localparam logic [7:0] PCO_CTRL_RST = 8'h18;  // Select 000, OE 1, SY 1
  localparam logic [7:0] PCO_TRIM_RST = 8'h00;  // No trim
  localparam logic [1:0] PCO_RESP_OK = 2'h0;    // OKAY
  localparam logic [1:0] PCO_RESP_ERR = 2'h2;   // SLVERR
endpackage : pco_pkg

// file: hdl/pco_square_wave_pin.sv
`timescale 1ns/1ps
module pco_square_wave_pin (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_clk_in,
  input wire logic timer_interrupt_signal,
  input wire logic battery_supply_state,
  input wire logic irq_event,
  output logic square_wave_pin
);
  import pco_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [2:0] sy1_ff;  // First stage
  logic [2:0] sy2_ff;  // Second stage
  logic osc_s;         // Oscillator level
  logic tmr_s;         // Timer interrupt level
  logic bak_s;         // Backup power state

  // Two flops per pin input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_ff <= 3'h0;
      sy2_ff <= 3'h0;
    end else begin
      sy1_ff <= {battery_supply_state, timer_interrupt_signal, osc_clk_in};
      sy2_ff <= sy1_ff;
    end
  end
  assign osc_s = sy2_ff[0];
  assign tmr_s = sy2_ff[1];
  assign bak_s = sy2_ff[2];

  // ==========================================================
  // Register file and bus slave
  logic [7:0] ctrl_ff, nxt_ctrl;    // Control fields
  logic flag_ff, nxt_flag;          // Interrupt output flag
  logic [7:0] trim_ff, nxt_trim;    // Oscillator trim value
  logic aw_have_ff, nxt_aw_have;    // Write address held
  logic w_have_ff, nxt_w_have;      // Write data held
  logic [3:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic prst_ff, nxt_prst;          // Prescaler reset pulse
  logic stop_ff, nxt_stop;          // Bus transaction ended
  logic wr_do;                      // Write executes now
  logic flag_clr;                   // Software clears flag
  logic flag_set;                   // Interrupt sets flag
  logic [2:0] sel;                  // Select field
  logic gate_ff, nxt_gate;          // Output gate
  logic [2:0] app_ff, nxt_app;      // Applied select
  logic pin_ff, nxt_pin;            // Registered pin

  assign sel = ctrl_ff[PCO_B_SEL_HI:PCO_B_SEL_LO];
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign wr_do = aw_have_ff && w_have_ff;
  assign flag_clr = wr_do && awaddr_ff == PCO_OFF_FLAG && wstrb_ff[0]
                    && !wdata_ff[PCO_B_FLAG];
  assign flag_set = irq_event && ctrl_ff[PCO_B_IE];

  // Next values of bus and register state
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_trim = trim_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_prst = 1'b0;
    nxt_stop = stop_ff;
    // Address and data are caught in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_have = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    // Write once both halves are held
    if (wr_do) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = PCO_RESP_OK;
      case (awaddr_ff)
        PCO_OFF_CTRL: begin
          if (wstrb_ff[0]) begin
            nxt_ctrl = wdata_ff[7:0] & ~(8'h01 << PCO_B_RST);
            nxt_prst = wdata_ff[PCO_B_RST];
          end
        end
        PCO_OFF_FLAG: ;  // Flag handled below
        PCO_OFF_TRIM: begin
          if (wstrb_ff[0]) begin
            nxt_trim = wdata_ff[7:0];
          end
        end
        PCO_OFF_STAT: ;  // Read only, write ignored
        default: nxt_bresp = PCO_RESP_ERR;  // Unmapped
      endcase
    end
    // Response handshake marks end of transaction
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
      nxt_stop = 1'b1;
    end else if (!gate_ff || ctrl_ff[PCO_B_OE] || flag_ff) begin
      nxt_stop = 1'b0;
    end
    // Read answer
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = PCO_RESP_OK;
      case (s_axi_araddr)
        PCO_OFF_CTRL: nxt_rdata = {24'h0, ctrl_ff};
        PCO_OFF_FLAG: nxt_rdata = {31'h0, flag_ff};
        PCO_OFF_TRIM: nxt_rdata = {24'h0, trim_ff};
        PCO_OFF_STAT: nxt_rdata = {26'h0, app_ff, pin_ff, bak_s, gate_ff};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = PCO_RESP_ERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    // Set wins over clear
    nxt_flag = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_ff);
  end

  // Register bus and register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= PCO_CTRL_RST;
      flag_ff <= 1'b0;
      trim_ff <= PCO_TRIM_RST;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= PCO_RESP_OK;
      rvalid_ff <= 1'b0;
      rresp_ff <= PCO_RESP_OK;
      rdata_ff <= 32'h0;
      prst_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      flag_ff <= nxt_flag;
      trim_ff <= nxt_trim;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      prst_ff <= nxt_prst;
      stop_ff <= nxt_stop;
    end
  end

  // ==========================================================
  // Prescaler and source selection
  logic osc_prev_ff;                       // Oscillator last level
  logic [PCO_DIV_W-1:0] cnt_ff, nxt_cnt;   // Falling-edge counter
  logic src_prev_ff;                       // Selected source last level
  logic osc_fall;                          // Oscillator falling edge
  logic src;                               // Selected source level
  logic src_fall;                          // Source falling edge
  logic active;                            // Output requested
  logic nosync;                            // Switch without waiting

  assign osc_fall = osc_prev_ff && !osc_s;

  // Divider with trim skip at each 1 Hz wrap
  always_comb begin
    nxt_cnt = cnt_ff;
    if (prst_ff) begin
      nxt_cnt = '0;
    end else if (osc_fall) begin
      if (&cnt_ff) begin
        nxt_cnt = {{(PCO_DIV_W-8){1'b0}}, trim_ff};
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  // Source multiplexer on the applied select
  always_comb begin
    case (app_ff)
      PCO_SEL_OSC: src = osc_s;
      PCO_SEL_8K: src = cnt_ff[PCO_TAP_8K];
      PCO_SEL_1K: src = cnt_ff[PCO_TAP_1K];
      PCO_SEL_64: src = cnt_ff[PCO_TAP_64];
      PCO_SEL_32: src = cnt_ff[PCO_TAP_32];
      PCO_SEL_1HZ: src = cnt_ff[PCO_TAP_1HZ];
      PCO_SEL_TMR: src = tmr_s && !prst_ff;
      default: src = 1'b0;
    endcase
  end
  assign src_fall = src_prev_ff && !src;

  // ==========================================================
  // Output gate
  assign active = ctrl_ff[PCO_B_OE] || flag_ff;
  assign nosync = !ctrl_ff[PCO_B_SY] || sel == PCO_SEL_TMR
                  || app_ff == PCO_SEL_TMR || app_ff == PCO_SEL_LOW;

  // Gate follows the enables at once when nosync, else opens and closes on source falling edges
  always_comb begin
    nxt_gate = gate_ff;
    nxt_app = app_ff;
    if (nosync) begin
      nxt_gate = active;
      nxt_app = sel;
    end else if (gate_ff) begin
      // Old source stops on its own falling edge
      if (src_fall && ((!active && stop_ff) || sel != app_ff)) begin
        nxt_gate = 1'b0;
      end
    end else begin
      nxt_app = sel;
      // New source starts on its falling edge
      if (active && src_fall && sel == app_ff) begin
        nxt_gate = 1'b1;
      end
    end
    // Pin level: gated source, low in backup state
    nxt_pin = gate_ff && src && !bak_s && app_ff != PCO_SEL_LOW;
  end

  // Prescaler, gate and pin registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev_ff <= 1'b0;
      cnt_ff <= '0;
      src_prev_ff <= 1'b0;
      gate_ff <= 1'b0;
      app_ff <= PCO_SEL_OSC;
      pin_ff <= 1'b0;
    end else begin
      osc_prev_ff <= osc_s;
      cnt_ff <= nxt_cnt;
      src_prev_ff <= src;
      gate_ff <= nxt_gate;
      app_ff <= nxt_app;
      pin_ff <= nxt_pin;
    end
  end
  assign square_wave_pin = pin_ff;

  // ==========================================================
  // Checks
  a_backup_low: assert property (@(posedge aclk) disable iff (!aresetn)
    bak_s |=> !square_wave_pin)
    else $error("pin high in backup state");
  a_select_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (app_ff == PCO_SEL_LOW || !gate_ff) |=> !square_wave_pin)
    else $error("pin high while disabled");
  a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_event && ctrl_ff[PCO_B_IE] |=> flag_ff)
    else $error("flag not set by interrupt");
  a_flag_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_ff && !ctrl_ff[PCO_B_IE] && !flag_clr |=> flag_ff)
    else $error("flag lost without clear");
  a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr && !flag_set |=> !flag_ff)
    else $error("flag not cleared");
  a_sync_start: assert property (@(posedge aclk) disable iff (!aresetn)
    !nosync && !gate_ff && active && src_fall && sel == app_ff |=> gate_ff)
    else $error("gate missed falling edge");
  a_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !nosync && gate_ff && !src_fall |=> gate_ff)
    else $error("gate closed off edge");
  a_nosync_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    nosync ##1 $stable(ctrl_ff) && $stable(flag_ff) |-> gate_ff == $past(active))
    else $error("gate not following enables");
  a_prescale_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    prst_ff |=> cnt_ff == '0)
    else $error("prescaler not cleared");
endmodule : pco_square_wave_pin

// file: verif/pco_ext_sys.sv
`timescale 1ns/1ps
// ==========================================================
// Far side: crystal source and a system that counts received clock edges
module pco_ext_sys (
  input wire logic aclk,
  input wire logic square_wave_pin,
  output logic osc_clk_in,
  output logic [15:0] rise_cnt
);
  logic last_pin = 1'b0;  // Pin level one cycle ago
  logic [15:0] rise_q = 16'h0;  // Rising edges counted so far
  assign rise_cnt = rise_q;
  // Crystal sped up to a 1.6 us period, phase offset from aclk
  initial begin
    osc_clk_in = 1'b0;
    #37;
    forever #800 osc_clk_in = ~osc_clk_in;
  end
  // Count rising edges of the received clock
  always @(posedge aclk) begin
    last_pin <= square_wave_pin;
    if (square_wave_pin && !last_pin) rise_q <= rise_q + 16'h1;
  end
endmodule : pco_ext_sys

// file: verif/programmable_clock_output_test.sv
`timescale 1ns/1ps
module programmable_clock_output_test;
  import pco_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc, pin;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic timer = 1'b0, battery = 1'b0, irq_event = 1'b0;
  logic [15:0] rise_cnt;
  logic seen_hi;  // Pin seen high during last span
  int rises;  // Rising edges during last span
  int err_count = 0;
  int num_checks = 0;
  logic [2:0] sel_tab [3] = '{3'h0, 3'h1, 3'h2};  // Sources measured
  int exp_tab [3] = '{128, 32, 4};  // Rises in 2048 cycles at 16-cycle osc
  pco_square_wave_pin uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .osc_clk_in(osc), .timer_interrupt_signal(timer),
    .battery_supply_state(battery), .irq_event(irq_event), .square_wave_pin(pin));
  pco_ext_sys ext (.aclk(aclk), .square_wave_pin(pin), .osc_clk_in(osc), .rise_cnt(rise_cnt));
  // ==========================================================
  // Clock, 100 ns period
  initial begin
    forever #50 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bus write, halves released as taken, waits for response
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw, ga, gw, done;
    @(posedge aclk);
    pa = 1'b1; pw = 1'b1; done = 1'b0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    while (!done) begin
      @(negedge aclk);
      ga = pa && awready;
      gw = pw && wready;
      if (bvalid) begin done = 1'b1; resp = bresp; end
      @(posedge aclk);
      if (ga) begin awvalid <= 1'b0; pa = 1'b0; end
      if (gw) begin wvalid <= 1'b0; pw = 1'b0; end
      if (done) bready <= 1'b0;
    end
  endtask : wr
  // Bus read, captures data and response at the handshake
  task automatic rd_reg(input logic [3:0] a);
    logic pa, ga, done;
    @(posedge aclk);
    pa = 1'b1; done = 1'b0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    while (!done) begin
      @(negedge aclk);
      ga = pa && arready;
      if (rvalid) begin done = 1'b1; rd = rdata; resp = rresp; end
      @(posedge aclk);
      if (ga) begin arvalid <= 1'b0; pa = 1'b0; end
      if (done) rready <= 1'b0;
    end
  endtask : rd_reg
  // Watch the pin for n cycles
  task automatic span(input int n);
    int start;
    start = rise_cnt;
    seen_hi = 1'b0;
    repeat (n) begin
      @(negedge aclk);
      seen_hi = seen_hi | (pin === 1'b1);
    end
    rises = int'(rise_cnt) - start;
  endtask : span
  task automatic in_rng(input string nm, input int lo, input int hi);
    chk(nm, {31'h0, (rises >= lo) && (rises <= hi)}, 32'h1);
  endtask : in_rng
  task automatic pulse_irq();
    @(posedge aclk);
    irq_event <= 1'b1;
    @(posedge aclk);
    irq_event <= 1'b0;
  endtask : pulse_irq
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // Watchdog, well beyond the planned run
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    close_out();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state and register access
    rd_reg(PCO_OFF_CTRL);
    chk("ctrl reset", rd, 32'h18);
    rd_reg(PCO_OFF_FLAG);
    chk("flag reset", rd, 32'h0);
    span(2048);
    in_rng("osc after reset", 125, 130);
    wr(4'h2, 32'hFF);
    chk("unmapped bresp", {30'h0, resp}, 32'h2);
    rd_reg(4'h2);
    chk("unmapped rresp", {30'h0, resp}, 32'h2);
    chk("unmapped rdata", rd, 32'h0);
    wr(PCO_OFF_TRIM, 32'h5A);
    rd_reg(PCO_OFF_TRIM);
    chk("trim", rd, 32'h5A);
    // Sources, disabled before each change
    for (int i = 0; i < 3; i++) begin
      wr(PCO_OFF_CTRL, 32'h0);
      wr(PCO_OFF_CTRL, {29'h1, sel_tab[i]});
      span(2048);
      in_rng("source rate", exp_tab[i] - 2, exp_tab[i] + 2);
    end
    // Synchronised stop
    wr(PCO_OFF_CTRL, 32'h1A);
    span(600);
    wr(PCO_OFF_CTRL, 32'h12);
    span(600);
    span(600);
    chk("sync stop low", {31'h0, seen_hi}, 32'h0);
    // Prescaler reset
    wr(PCO_OFF_CTRL, 32'h0A);
    span(600);
    wr(PCO_OFF_CTRL, 32'h4A);
    repeat (8) @(posedge aclk);
    span(200);
    chk("reset bit low", {31'h0, seen_hi}, 32'h0);
    rd_reg(PCO_OFF_CTRL);
    chk("reset bit reads 0", rd, 32'h0A);
    wr(PCO_OFF_CTRL, 32'h0);
    wr(PCO_OFF_CTRL, 32'h48);
    span(320);
    in_rng("reset bit osc", 18, 22);
    // Constant low select
    wr(PCO_OFF_CTRL, 32'h0F);
    // Old source may still reach the pin for a cycle or two
    repeat (4) @(posedge aclk);
    span(300);
    chk("select low", {31'h0, seen_hi}, 32'h0);
    // Backup power state and return
    wr(PCO_OFF_CTRL, 32'h0);
    wr(PCO_OFF_CTRL, 32'h08);
    @(posedge aclk);
    battery <= 1'b1;
    repeat (8) @(posedge aclk);
    span(300);
    chk("backup low", {31'h0, seen_hi}, 32'h0);
    @(posedge aclk);
    battery <= 1'b0;
    span(320);
    in_rng("backup return", 14, 22);
    // Interrupt driven output
    wr(PCO_OFF_CTRL, 32'h0);
    pulse_irq();
    rd_reg(PCO_OFF_FLAG);
    chk("flag masked", rd, 32'h0);
    wr(PCO_OFF_CTRL, 32'h20);
    pulse_irq();
    rd_reg(PCO_OFF_FLAG);
    chk("flag set", rd, 32'h1);
    span(320);
    in_rng("irq output", 17, 22);
    wr(PCO_OFF_CTRL, 32'h0);
    span(320);
    in_rng("irq output kept", 17, 22);
    wr(PCO_OFF_FLAG, 32'h0);
    rd_reg(PCO_OFF_FLAG);
    chk("flag cleared", rd, 32'h0);
    repeat (8) @(posedge aclk);
    span(300);
    chk("irq output off", {31'h0, seen_hi}, 32'h0);
    // Timer source with sync bit set
    wr(PCO_OFF_CTRL, 32'h1E);
    @(posedge aclk);
    timer <= 1'b1;
    span(12);
    chk("timer high", {31'h0, pin}, 32'h1);
    @(posedge aclk);
    timer <= 1'b0;
    span(12);
    chk("timer low", {31'h0, pin}, 32'h0);
    close_out();
  end
endmodule : programmable_clock_output_test
